// >>> core/dtrc_channel.v
/*
  one dma channel's transfer sequencing: request qualification, single/block, one/four burst,
  acknowledge pulse of programmable width, count down to idle.
  assumes control and count are written by software while idle; the bus data path sits outside
  and accepts one source/target pair per cycle of bus_read/bus_write.
*/
`timescale 1ns/1ns
`include "dtrc_defines.vh"

// Behaviour
// [R01] move data from source party to target
// [R02] software programs addresses, count, control first
// [R03] start only on a service request
// [R04] go idle once whole buffer moved
// [R05] software reprograms before every further buffer
// [R06] single mode: one unit or four-unit burst
// [R07] single mode: one request per unit, wait
// [R08] requester drops request only after acknowledge
// [R09] block mode: one request moves everything
// [R10] block transfer ends when count hits zero
// [R11] all sequencing synchronous to system clock
// [R12] mode 001, block 0, burst 0 selects single
// [R13] request and acknowledge both active high
// [R14] extra pulses during service are ignored
// [R15] request still high after ack: new request
// [R16] requester should drop request during ack
// [R17] ack width programmable 1 to 16 cycles (code: held through the beats plus 1 to 16 cycles, so 3 to 18 for one unit)
// [R18] ext request routing to channel pairs
// [R19] block mode only in external request mode
// [R20] four-burst count minus four, tail per unit
// [R21] count reduced per unit, stop at zero

module dtrc_channel #(
  parameter CNT_W   = 24,
  parameter CHAN_ID = 0
) (
  // clock and reset
  input  wire             mclk,
  input  wire             sys_rst,
  // software programming
  input  wire [16:0]      channel_control_reg,
  input  wire [CNT_W-1:0] transfer_count_reg,
  input  wire             program_strobe,
  // request sources
  input  wire [3:0]       ext_xfer_request,
  input  wire             fast_serial_port0,
  input  wire             fast_serial_port1,
  input  wire             cipher_request,
  // external acknowledge
  output reg              ext_xfer_ack,
  // bus sequencing toward the data path
  output reg              bus_read,
  output reg              bus_write,
  output reg  [1:0]       bus_size,
  output reg  [CNT_W-1:0] count_left,
  output reg              busy,
  output reg              done
);

  // ----------------------------------------
  // states
  // ----------------------------------------
  localparam ST_IDLE  = 3'h0;
  localparam ST_WAIT  = 3'h1;
  localparam ST_READ  = 3'h2;
  localparam ST_WRITE = 3'h3;
  localparam ST_ACK   = 3'h4;

  // ----------------------------------------
  // request pin synchronisers
  // ----------------------------------------
  reg [3:0] req_s1;
  reg [3:0] req_s2;
  always @(posedge mclk) begin                                              // [R11]
    if (sys_rst) begin
      req_s1 <= 4'h0;
      req_s2 <= 4'h0;
    end else begin
      req_s1 <= ext_xfer_request;
      req_s2 <= req_s1;
    end
  end

  // external request line routing per channel
  function dtrc_ext_pick;
    input [3:0] req;
    input integer ch;
    begin
      case (ch)
        0, 4:    dtrc_ext_pick = req[0];                                    // [R18]
        1, 5:    dtrc_ext_pick = req[1];
        2:       dtrc_ext_pick = req[2];
        3:       dtrc_ext_pick = req[3];
        default: dtrc_ext_pick = 1'b0;
      endcase
    end
  endfunction

  // ----------------------------------------
  // latched control
  // ----------------------------------------
  reg  [16:0] ctl;
  wire [2:0]  mode     = ctl[`DTRC_CTL_MODE_HI:`DTRC_CTL_MODE_LO];
  wire        ext_mode = (mode == `DTRC_MODE_EXT);                         // [R12]
  wire        blk      = ctl[`DTRC_CTL_BLOCK] & ext_mode;                   // [R19]
  wire        b4       = ctl[`DTRC_CTL_BURST4];
  wire [3:0]  ack_w    = ctl[`DTRC_CTL_ACKW_HI:`DTRC_CTL_ACKW_LO];
  wire        fsp_req  = (CHAN_ID < 3) ? fast_serial_port0 : fast_serial_port1;

  reg  src_req;
  always @* begin
    case (mode)                                                             // [R03]
      `DTRC_MODE_SOFT:     src_req = 1'b1;
      `DTRC_MODE_EXT:      src_req = dtrc_ext_pick(req_s2, CHAN_ID);       // [R13]
      `DTRC_MODE_FSP_TX,
      `DTRC_MODE_FSP_RX:   src_req = fsp_req;
      `DTRC_MODE_CIPH_IN,
      `DTRC_MODE_CIPH_OUT: src_req = cipher_request;
      default:             src_req = 1'b0;
    endcase
  end

  // ----------------------------------------
  // counter submodule
  // ----------------------------------------
  wire             cnt_load;
  reg              cnt_step;
  wire [CNT_W-1:0] remaining;
  wire [CNT_W-1:0] step_bytes;
  wire             last_step;

  dtrc_unit_step #(
    .CNT_W (CNT_W)
  ) u_step (
    .mclk       (mclk),
    .sys_rst    (sys_rst),
    .load       (cnt_load),
    .load_val   (transfer_count_reg),
    .step       (cnt_step),
    .xfer_size  (ctl[`DTRC_CTL_SIZE_HI:`DTRC_CTL_SIZE_LO]),
    .burst4     (b4),
    .remaining  (remaining),
    .step_bytes (step_bytes),
    .last_step  (last_step)
  );

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  reg [2:0] state;
  reg [2:0] beat;
  reg [3:0] ack_cnt;
  reg [2:0] beats;
  reg       run;

  // count loads on the strobe edge itself, so the first wait cycle already sees the new count
  assign cnt_load = (state == ST_IDLE) && program_strobe;

  // beats per grant; a chained block grant must look past the step still pending in the counter
  wire [1:0]       size_sel   = ctl[`DTRC_CTL_SIZE_HI:`DTRC_CTL_SIZE_LO];
  wire [CNT_W-1:0] unit_now   = (size_sel == 2'h0) ? {{(CNT_W-1){1'b0}}, 1'b1} :
                                (size_sel == 2'h1) ? {{(CNT_W-2){1'b0}}, 2'h2} :
                                                     {{(CNT_W-3){1'b0}}, 3'h4};
  wire [CNT_W-1:0] burst_now  = unit_now << 2;
  wire [CNT_W-1:0] rem_after  = remaining - step_bytes;
  wire [2:0]       beats_now  = (b4 && remaining >= burst_now) ? `DTRC_BURST_UNITS : 3'h1;
  wire [2:0]       beats_next = (b4 && rem_after >= burst_now) ? `DTRC_BURST_UNITS : 3'h1;

  always @(posedge mclk) begin
    cnt_step <= 1'b0;
    done     <= 1'b0;
    if (sys_rst) begin
      state        <= ST_IDLE;
      ctl          <= `DTRC_CTL_RESET;
      run          <= 1'b0;
      beat         <= 3'h0;
      beats        <= 3'h1;
      ack_cnt      <= 4'h0;
      ext_xfer_ack <= 1'b0;
      bus_read     <= 1'b0;
      bus_write    <= 1'b0;
      bus_size     <= 2'h0;
      count_left   <= `DTRC_CNT_RESET;
      busy         <= 1'b0;
    end else begin
      count_left <= remaining;
      case (state)
        ST_IDLE: begin
          busy <= 1'b0;
          if (program_strobe) begin                                         // [R02] [R05]
            ctl      <= channel_control_reg;
            run      <= channel_control_reg[`DTRC_CTL_RUN];
            state    <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          busy <= 1'b1;
          if (run && remaining == {CNT_W{1'b0}}) begin
            run   <= 1'b0;                                                  // [R04]
            done  <= 1'b1;
            state <= ST_IDLE;
          end else if (run && src_req) begin                                // [R07]
            beats    <= beats_now;
            beat     <= 3'h0;
            bus_size <= ctl[`DTRC_CTL_SIZE_HI:`DTRC_CTL_SIZE_LO];
            bus_read <= 1'b1;                                               // [R01]
            if (ext_mode) begin
              ext_xfer_ack <= 1'b1;
            end
            state <= ST_READ;
          end
        end
        ST_READ: begin
          // four-burst: all reads, then all writes
          if (beat == beats - 3'h1) begin
            bus_read  <= 1'b0;
            bus_write <= 1'b1;
            beat      <= 3'h0;
            state     <= ST_WRITE;
          end else begin
            beat <= beat + 3'h1;
          end
        end
        ST_WRITE: begin
          if (beat == beats - 3'h1) begin
            bus_write <= 1'b0;
            cnt_step  <= 1'b1;                                              // [R21] [R20]
            if (blk && !last_step) begin                                    // [R09]
              beats    <= beats_next;
              beat     <= 3'h0;
              bus_read <= 1'b1;
              state    <= ST_READ;
            end else begin
              ack_cnt <= 4'h0;
              state   <= ST_ACK;
            end
          end else begin
            beat <= beat + 3'h1;
          end
        end
        ST_ACK: begin
          // extra request pulses here are not counted; the pin is resampled once ack drops
          ack_cnt <= ack_cnt + 4'h1;                                        // [R14]
          if (!ext_mode || ack_cnt >= ack_w) begin                          // [R17]
            ext_xfer_ack <= 1'b0;                                           // [R15] [R16] [R08]
            state        <= ST_WAIT;                                        // [R10]
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

endmodule

// >>> inc/dtrc_defines.vh
/*
  constants for the dma transfer request control block: mode codes, field positions, reset values, timing.
  assumes inclusion by bare name from the design files.
*/
`ifndef DTRC_DEFINES_VH
`define DTRC_DEFINES_VH

// ----------------------------------------
// mode field codes (control bits [3:1])
// ----------------------------------------
`define DTRC_MODE_SOFT     3'h0
`define DTRC_MODE_EXT      3'h1
`define DTRC_MODE_FSP_TX   3'h2
`define DTRC_MODE_FSP_RX   3'h3
`define DTRC_MODE_CIPH_IN  3'h4
`define DTRC_MODE_CIPH_OUT 3'h5

// ----------------------------------------
// control field positions
// ----------------------------------------
`define DTRC_CTL_RUN       0
`define DTRC_CTL_MODE_LO   1
`define DTRC_CTL_MODE_HI   3
`define DTRC_CTL_BLOCK     4
`define DTRC_CTL_BURST4    5
`define DTRC_CTL_SIZE_LO   6
`define DTRC_CTL_SIZE_HI   7
`define DTRC_CTL_ACKW_LO   13
`define DTRC_CTL_ACKW_HI   16

// ----------------------------------------
// reset values and timing
// ----------------------------------------
`define DTRC_CTL_RESET     17'h00000
`define DTRC_CNT_RESET     24'h000000
`define DTRC_BURST_UNITS   3'h4
`define DTRC_CLK_MHZ       50
`define DTRC_GAP_CYCLES    4'h2

`endif

// >>> core/dtrc_unit_step.v
/*
  holds the remaining transfer count and works out the bytes of the next unit or burst.
  assumes the controller loads it at start and pulses step once per moved unit or burst.
*/
`timescale 1ns/1ns
`include "dtrc_defines.vh"

module dtrc_unit_step #(
  parameter CNT_W = 24
) (
  // clock and reset
  input  wire             mclk,
  input  wire             sys_rst,
  // control
  input  wire             load,
  input  wire [CNT_W-1:0] load_val,
  input  wire             step,
  input  wire [1:0]       xfer_size,
  input  wire             burst4,
  // status
  output reg  [CNT_W-1:0] remaining,
  output wire [CNT_W-1:0] step_bytes,
  output wire             last_step
);

  // ----------------------------------------
  // unit sizing
  // ----------------------------------------
  function [CNT_W-1:0] dtrc_unit_bytes;
    input [1:0] sz;
    begin
      case (sz)
        2'h0:    dtrc_unit_bytes = {{(CNT_W-1){1'b0}}, 1'b1};
        2'h1:    dtrc_unit_bytes = {{(CNT_W-2){1'b0}}, 2'h2};
        default: dtrc_unit_bytes = {{(CNT_W-3){1'b0}}, 3'h4};
      endcase
    end
  endfunction

  wire [CNT_W-1:0] unit = dtrc_unit_bytes(xfer_size);
  wire [CNT_W-1:0] burst = unit << 2;

  // a misaligned tail goes one unit at a time, and a last part unit as the bytes left
  assign step_bytes = (burst4 && remaining >= burst) ? burst :              // [R06] [R20]
                      (remaining >= unit) ? unit : remaining;
  assign last_step  = (remaining <= step_bytes);                            // [R10]

  // ----------------------------------------
  // counter
  // ----------------------------------------
  always @(posedge mclk) begin
    if (sys_rst) begin
      remaining <= `DTRC_CNT_RESET;
    end else if (load) begin
      remaining <= load_val;
    end else if (step) begin
      remaining <= remaining - step_bytes;                                  // [R21]
    end
  end

endmodule

// >>> verification/dtrc_ext_requester.sv
/*
  external requester model driving the channel's request pin 0.
  assumes one shared clock; go is a one-cycle pulse from the bench.
*/
`timescale 1ns/1ns
module dtrc_ext_requester (
  // clock and reset
  input  wire       mclk,
  input  wire       sys_rst,
  // handshake
  input  wire       ext_xfer_ack,
  input  wire       go,
  input  wire [1:0] style,
  output reg        ext_xfer_request
);
  reg [1:0] k;
  always @(posedge mclk) begin
    if (sys_rst) begin
      ext_xfer_request <= 1'b0;
      k                <= 2'h0;
    end else begin
      k <= !ext_xfer_ack ? 2'h0 : (k == 2'h3 ? k : k + 2'h1);
      case (style)
        // hold until ack is seen, so no stray second unit
        2'h0: ext_xfer_request <= (ext_xfer_request | go) & ~ext_xfer_ack;
        // stuck high: asks for back-to-back units
        2'h1: ext_xfer_request <= 1'b1;
        // stray pulses early in the ack window, low again before ack ends
        default: ext_xfer_request <= go | (ext_xfer_ack & ~ext_xfer_request & (k != 2'h3));
      endcase
    end
  end
endmodule

// >>> verification/dtrc_channel_sva.sv
/*
  port assertions for the dma channel.
  assumes control stays steady from program strobe until done.
*/
`timescale 1ns/1ns
module dtrc_channel_sva #(
  parameter CNT_W = 24
) (
  // clock and reset
  input wire             mclk,
  input wire             sys_rst,
  // inputs
  input wire [16:0]      channel_control_reg,
  input wire [3:0]       ext_xfer_request,
  // outputs
  input wire             ext_xfer_ack,
  input wire             bus_read,
  input wire             bus_write,
  input wire [CNT_W-1:0] count_left,
  input wire             busy,
  input wire             done
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  wire ext_mode = channel_control_reg[3:1] == 3'h1;
  AST_RW_EXCL: assert property (!(bus_read && bus_write))
    else $error("read and write overlap");
  AST_WR_AFTER_RD: assert property ($fell(bus_read) |-> bus_write)
    else $error("read not followed by write");
  AST_BURST_MAX: assert property (bus_read [*4] |=> !bus_read)
    else $error("more than four reads in a row");
  AST_DONE_IDLE: assert property (done |=> !busy)
    else $error("busy after done");
  AST_NO_BUS_IDLE: assert property (!busy |-> !bus_read && !bus_write)
    else $error("bus cycle while idle");
  AST_DONE_ZERO: assert property (done |-> count_left == {CNT_W{1'b0}})
    else $error("done with count left");
  AST_SOFT_NO_ACK: assert property (channel_control_reg[3:1] == 3'h0 |-> !ext_xfer_ack)
    else $error("ack in software mode");
  AST_ACK_BEATS: assert property (ext_mode && (bus_read || bus_write) |-> ext_xfer_ack)
    else $error("beat without ack");
  AST_ACK_TAIL: assert property (ext_mode && $fell(bus_write) |-> ext_xfer_ack)
    else $error("ack dropped with last write");
  cover property (done);
  cover property (bus_read [*4]);
  cover property (ext_xfer_ack && ext_xfer_request[0]);
endmodule

// >>> verification/dtrc_channel_tb_top.sv
/*
  bench for one dma channel against the external requester model.
  assumes channel 0, so only request pin 0 is live.
*/
`timescale 1ns/1ns
module dtrc_channel_tb_top;
  reg         mclk, sys_rst, stb, go;
  reg  [16:0] ctl;
  reg  [23:0] cnt;
  reg  [1:0]  sty;
  reg  [2:0]  oreq;
  reg         clr;
  reg  [1:0]  sz_seen;
  wire        req, ack, rd, wr, busy, done;
  wire [1:0]  sz_o;
  wire [23:0] left;
  integer     failures, checks, nrd, nwr, nack, i;
  dtrc_channel dut (.mclk(mclk), .sys_rst(sys_rst), .channel_control_reg(ctl),
    .transfer_count_reg(cnt), .program_strobe(stb), .ext_xfer_request({oreq, req}),
    .fast_serial_port0(1'b0), .fast_serial_port1(1'b0), .cipher_request(1'b0),
    .ext_xfer_ack(ack), .bus_read(rd), .bus_write(wr), .bus_size(sz_o),
    .count_left(left), .busy(busy), .done(done));
  dtrc_ext_requester peer (.mclk(mclk), .sys_rst(sys_rst), .ext_xfer_ack(ack),
    .go(go), .style(sty), .ext_xfer_request(req));
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  // beat counters; cleared on the same edge that samples each program strobe
  always @(posedge mclk) begin
    if (sys_rst || clr) begin
      nrd     <= 0;
      nwr     <= 0;
      nack    <= 0;
      sz_seen <= 2'h0;
    end else begin
      nrd  <= nrd + rd;
      nwr  <= nwr + wr;
      nack <= nack + ack;
      if (rd) begin
        sz_seen <= sz_o;
      end
    end
  end
  task chk(input [63:0] nm, input [31:0] got, input [31:0] exp);
    begin
      checks = checks + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("BAD %0s exp %0h got %0h", nm, exp, got);
      end
    end
  endtask
  task tally_and_finish;
    begin
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  // software writes control and count while idle
  task prog(input [2:0] md, input blk, input b4, input [1:0] sz, input [3:0] aw, input [23:0] n);
    begin
      @(posedge mclk);
      ctl <= {aw, 5'h00, sz, b4, blk, md, 1'b1};
      cnt <= n;
      stb <= 1'b1;
      clr <= 1'b1;
      @(posedge mclk);
      stb <= 1'b0;
      clr <= 1'b0;
    end
  endtask
  task kick(input [1:0] s);
    begin
      @(posedge mclk);
      sty <= s;
      go  <= 1'b1;
      @(posedge mclk);
      go  <= 1'b0;
    end
  endtask
  // bounded wait; a hang ends the run as a failure
  task wait_done;
    begin
      i = 0;
      while (done !== 1'b1 && i < 300) begin
        @(negedge mclk);
        i = i + 1;
      end
      if (done !== 1'b1) begin
        failures = failures + 1;
        tally_and_finish;
      end else begin
        repeat (3) @(negedge mclk);
        chk("busy", busy, 0);
      end
    end
  endtask
  task t_hold;
    begin
      prog(3'h1, 1'b0, 1'b0, 2'h0, 4'h0, 24'h000002);
      kick(2'h1);
      wait_done;
      chk("reads", nrd, 2);
      chk("acks", nack, 6);
      chk("left", left, 0);
      @(posedge mclk);
      sty <= 2'h2;
      // let the stuck-high level drain out of the synchroniser before the next program
      repeat (4) @(posedge mclk);
      $display("end hold");
    end
  endtask
  task t_storm;
    begin
      prog(3'h1, 1'b0, 1'b0, 2'h0, 4'h3, 24'h000002);
      oreq <= 3'h7;
      repeat (20) @(negedge mclk);
      chk("idle rd", nrd, 0);
      @(posedge mclk);
      oreq <= 3'h0;
      kick(2'h2);
      repeat (30) @(negedge mclk);
      chk("reads", nrd, 1);
      chk("acks", nack, 6);
      kick(2'h0);
      wait_done;
      chk("reads", nrd, 2);
      $display("end storm");
    end
  endtask
  task t_block;
    begin
      prog(3'h1, 1'b1, 1'b0, 2'h1, 4'h0, 24'h000008);
      kick(2'h0);
      wait_done;
      chk("reads", nrd, 4);
      chk("writes", nwr, 4);
      chk("size", sz_seen, 1);
      $display("end block");
    end
  endtask
  task t_burst;
    begin
      prog(3'h1, 1'b0, 1'b1, 2'h0, 4'h0, 24'h000005);
      kick(2'h0);
      repeat (30) @(negedge mclk);
      chk("reads", nrd, 4);
      chk("left", left, 1);
      kick(2'h0);
      wait_done;
      chk("reads", nrd, 5);
      $display("end burst");
    end
  endtask
  task t_soft;
    begin
      prog(3'h0, 1'b0, 1'b0, 2'h2, 4'h0, 24'h000004);
      wait_done;
      chk("reads", nrd, 1);
      chk("acks", nack, 0);
      chk("size", sz_seen, 2);
      $display("end soft");
    end
  endtask
  initial begin
    failures = 0;
    checks   = 0;
    clr      = 1'b0;
    oreq     = 3'h0;
    sys_rst  = 1'b1;
    stb      = 1'b0;
    go       = 1'b0;
    sty      = 2'h2;
    ctl      = 17'h00000;
    cnt      = 24'h000000;
    repeat (8) @(posedge mclk);
    sys_rst <= 1'b0;
    t_hold;
    t_storm;
    t_block;
    t_burst;
    t_soft;
    tally_and_finish;
  end
endmodule
bind dtrc_channel dtrc_channel_sva #(.CNT_W(CNT_W)) sva_i (.mclk(mclk), .sys_rst(sys_rst),
  .channel_control_reg(channel_control_reg), .ext_xfer_request(ext_xfer_request),
  .ext_xfer_ack(ext_xfer_ack), .bus_read(bus_read), .bus_write(bus_write),
  .count_left(count_left), .busy(busy), .done(done));
